// >>> design/intc_pkg.sv
package intc_pkg;

	// =====================================================
	// register map and fields
	localparam logic [1:0] ofs_vector_control  = 2'h0;
	localparam logic [1:0] ofs_executing_flags = 2'h1;
	localparam logic [1:0] ofs_last_ack        = 2'h2;
	localparam logic [1:0] ofs_promoted        = 2'h3;
	localparam int         bit_rotation        = 0;
	localparam int         bit_compact         = 5;
	localparam int         bit_placement       = 6;
	localparam int         bit_nm_exec         = 7;
	localparam int         bit_hi_exec         = 1;
	localparam int         bit_no_exec         = 0;
	localparam logic [7:0] reset_byte          = 8'h00;

	// =====================================================
	// vectors and protection
	localparam int         num_vec             = 32;
	localparam logic [7:0] compact_nm_vec      = 8'h01;
	localparam logic [7:0] compact_hi_vec      = 8'h02;
	localparam logic [7:0] compact_no_vec      = 8'h03;
	localparam logic [7:0] io_register_key     = 8'hd8;
	localparam int         protect_window      = 4;
	localparam logic [2:0] protect_window_cnt  = 3'h4;

	// =====================================================
	// carriers
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;

	typedef struct packed {
		logic       ack;
		logic [7:0] vector;
		logic       placement;
	} vec_out_s;

	typedef struct packed {
		logic       placement;
		logic       compact;
		logic       rotation;
		logic [7:0] last_ack;
		logic [7:0] promoted;
		logic       nm_exec;
		logic       hi_exec;
		logic       no_exec;
		logic [2:0] window;
		logic [7:0] rdata;
		vec_out_s   vout;
	} state_s;

endpackage

// >>> design/priority_interrupt_controller.sv
// Overview of operation
// - non-maskable requests are served whatever the global enable, never touch it
// - while a non-maskable handler runs, nothing else is acknowledged
// - pending non-maskable requests are taken lowest vector first
// - without rotation, lowest pending normal vector wins
// - control bit 0 written one switches normal arbitration to rotation
// - with rotation, last acknowledged normal vector gets lowest priority next
// - compact table: non-maskable at 1, high at 2, normal share 3
// - key then protected write within four instructions, else unchanged
// - placement and compact bits protected, rotation bit freely writable
// - placement bit picks application base (0) or boot base (1)
// - non-maskable executing flag set while its handler runs, cleared on return
// - high executing flag held also while preempted by non-maskable
// - normal executing flag held also while preempted by higher levels
// - with rotation, each acknowledged normal vector is recorded in last-ack
// - reset starts lowest-first and clears last-ack register
// - promoted vector zero means no high-level source at all
// - promoted source preempts normal handler, which resumes after its return
// - maskable requests only when global enable is one; never cleared here
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller
	import intc_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// register port
	input  wire intc_pkg::reg_req_s   reg_req,
	output logic [7:0]                reg_rdata,
	// core side
	input  wire logic                 global_enable,
	input  wire logic                 core_take,
	input  wire logic                 core_instr_done,
	input  wire logic                 interrupt_return,
	input  wire logic                 change_protection_wr,
	input  wire logic [7:0]           change_protection_data,
	output intc_pkg::vec_out_s        vec_out,
	output logic                      irq_pending,
	// sources
	input  wire logic [num_vec-1:0]   req,
	input  wire logic [num_vec-1:0]   nm_lines
);

	// =====================================================
	// state
	state_s s_q;
	state_s s_d;
	logic   pend_q;
	logic   pend_d;

	// =====================================================
	// arbitration
	logic [num_vec-1:0] nm_req;
	logic [num_vec-1:0] mk_req;
	logic [num_vec-1:0] hi_mask;
	logic [num_vec-1:0] after_last;
	logic               hi_req;
	logic               nm_any;
	logic               no_any;
	logic [7:0]         nm_win;
	logic [7:0]         no_fix;
	logic [7:0]         no_rot;
	logic [7:0]         no_win;
	logic               rot_hit;

	genvar g;
	generate
		for (g = 0; g < num_vec; g++) begin : g_vec
			assign nm_req[g]     = req[g] & nm_lines[g];
			assign mk_req[g]     = req[g] & ~nm_lines[g];
			// promoted vector zero names no source
			assign hi_mask[g]    = (s_q.promoted != 8'h00) &&
			                       (s_q.promoted == 8'(g));
			assign after_last[g] = 8'(g) > s_q.last_ack;
		end
	endgenerate

	assign hi_req = |(mk_req & hi_mask);
	assign nm_any = |nm_req;
	assign no_any = |(mk_req & ~hi_mask);

	always_comb begin
		nm_win  = 8'h00;
		no_fix  = 8'h00;
		no_rot  = 8'h00;
		rot_hit = 1'b0;
		// descending scan leaves lowest index winning
		for (int i = num_vec - 1; i >= 0; i--) begin
			if (nm_req[i]) begin
				nm_win = 8'(i);
			end
			if (mk_req[i] && !hi_mask[i]) begin
				no_fix = 8'(i);
			end
			if (mk_req[i] && !hi_mask[i] && after_last[i]) begin
				no_rot  = 8'(i);
				rot_hit = 1'b1;
			end
		end
		// vectors above the last one first, then wrap to lowest
		no_win = (s_q.rotation && rot_hit) ? no_rot : no_fix;
	end

	// =====================================================
	// next state
	logic       may_nm;
	logic       may_hi;
	logic       may_no;
	logic [7:0] ctrl_rd;
	logic [7:0] stat_rd;

	always_comb begin
		// nothing interrupts a non-maskable handler
		may_nm = !s_q.nm_exec;
		// high level only preempts normal, and needs global enable
		may_hi = !s_q.nm_exec && !s_q.hi_exec && global_enable &&
		         hi_req;
		may_no = !s_q.nm_exec && !s_q.hi_exec && !s_q.no_exec &&
		         global_enable && no_any;

		ctrl_rd                = reset_byte;
		ctrl_rd[bit_placement] = s_q.placement;
		ctrl_rd[bit_compact]   = s_q.compact;
		ctrl_rd[bit_rotation]  = s_q.rotation;
		stat_rd                = reset_byte;
		stat_rd[bit_nm_exec]   = s_q.nm_exec;
		stat_rd[bit_hi_exec]   = s_q.hi_exec;
		stat_rd[bit_no_exec]   = s_q.no_exec;

		s_d         = s_q;
		s_d.vout.ack = 1'b0;
		s_d.vout.placement = s_q.placement;
		pend_d = 1'b0;
		if (s_q.window != 3'h0 && core_instr_done) begin
			s_d.window = s_q.window - 3'h1;
		end
		if (change_protection_wr &&
		    change_protection_data == io_register_key) begin
			s_d.window = protect_window_cnt;
		end

		// return clears the highest level that is running
		if (interrupt_return) begin
			if (s_q.nm_exec) begin
				s_d.nm_exec = 1'b0;
			end else if (s_q.hi_exec) begin
				s_d.hi_exec = 1'b0;
			end else begin
				s_d.no_exec = 1'b0;
			end
		end

		// core gates the take by its own one-instruction rule
		if (may_nm && nm_any) begin
			pend_d = 1'b1;
		end else if (may_hi || may_no) begin
			pend_d = 1'b1;
		end
		if (core_take && !interrupt_return) begin
			if (may_nm && nm_any) begin
				s_d.nm_exec     = 1'b1;
				s_d.vout.ack    = 1'b1;
				s_d.vout.vector = s_q.compact ? compact_nm_vec
				                              : nm_win;
			end else if (may_hi) begin
				s_d.hi_exec     = 1'b1;
				s_d.vout.ack    = 1'b1;
				s_d.vout.vector = s_q.compact ? compact_hi_vec
				                              : s_q.promoted;
			end else if (may_no) begin
				s_d.no_exec     = 1'b1;
				s_d.vout.ack    = 1'b1;
				s_d.vout.vector = s_q.compact ? compact_no_vec
				                              : no_win;
				if (s_q.rotation) begin
					s_d.last_ack = no_win;
				end
			end
			pend_d = 1'b0;
		end

		// register writes
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				ofs_vector_control: begin
					s_d.rotation = reg_req.wdata[bit_rotation];
					if (s_q.window != 3'h0) begin
						s_d.placement = reg_req.wdata[bit_placement];
						s_d.compact   = reg_req.wdata[bit_compact];
						s_d.window    = 3'h0;
					end
				end
				ofs_last_ack: s_d.last_ack = reg_req.wdata;
				ofs_promoted: s_d.promoted = reg_req.wdata;
				ofs_executing_flags: begin
				end
			endcase
		end

		s_d.rdata = reset_byte;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				ofs_vector_control:  s_d.rdata = ctrl_rd;
				ofs_executing_flags: s_d.rdata = stat_rd;
				ofs_last_ack:        s_d.rdata = s_q.last_ack;
				ofs_promoted:        s_d.rdata = s_q.promoted;
			endcase
		end
	end

	// =====================================================
	// registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q    <= '0;
			pend_q <= 1'b0;
		end else begin
			s_q    <= s_d;
			pend_q <= pend_d;
		end
	end

	assign reg_rdata   = s_q.rdata;
	assign vec_out     = s_q.vout;
	assign irq_pending = pend_q;

endmodule
`default_nettype wire

// >>> tb/intc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module intc_chk
	import intc_pkg::*;
(
	// ========
	// watched ports
	input wire logic               clk,
	input wire logic               rst,
	input wire intc_pkg::reg_req_s reg_req,
	input wire logic [7:0]         reg_rdata,
	input wire logic               global_enable,
	input wire logic               core_take,
	input wire logic               interrupt_return,
	input wire intc_pkg::vec_out_s vec_out,
	input wire logic               irq_pending,
	input wire logic [num_vec-1:0] req,
	input wire logic [num_vec-1:0] nm_lines
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] nm_lo;
	// ========
	// lowest pending non-maskable line
	always_comb begin
		nm_lo = 8'h00;
		for (int i = num_vec - 1; i >= 0; i--)
			if (req[i] && nm_lines[i]) nm_lo = 8'(i);
	end
	ack_cause_a: assert property (vec_out.ack |->
		$past(core_take && !interrupt_return && req != '0)) else $error("ack");
	mask_gate_a: assert property (core_take && !global_enable &&
		(req & nm_lines) == '0 |=> !vec_out.ack) else $error("masked ack");
	nm_lowest_a: assert property (vec_out.ack && $past(|(req & nm_lines))
		|-> vec_out.vector == $past(nm_lo) || vec_out.vector == compact_nm_vec)
		else $error("nm order");
	vec_hold_a: assert property (!vec_out.ack |-> $stable(vec_out.vector))
		else $error("vector moved");
	rd_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
		else $error("rdata idle");
	pend_idle_a: assert property ($past(req) == '0 && $past(req, 2) == '0
		|-> !irq_pending) else $error("pending idle");
	place_src_a: assert property ($changed(vec_out.placement) |->
		vec_out.ack || $past(reg_req.wr) || $past(reg_req.wr, 2))
		else $error("placement");
	stat_rsvd_a: assert property (
		$past(reg_req.rd && reg_req.addr == ofs_executing_flags)
		|-> reg_rdata[6:2] == 5'h00) else $error("status reserved");
endmodule
bind priority_interrupt_controller intc_chk i_chk (.clk, .rst, .reg_req,
	.reg_rdata, .global_enable, .core_take, .interrupt_return, .vec_out,
	.irq_pending, .req, .nm_lines);
`default_nettype wire

// >>> tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// ========
	// clock and controls
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic irq_pending,
	input  wire logic ret_cmd,
	input  wire logic slow,
	// core strobes
	output logic      core_take,
	output logic      core_instr_done,
	output logic      interrupt_return
);
	logic ran_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_take <= 1'b0;
			core_instr_done <= 1'b0;
			interrupt_return <= 1'b0;
			ran_q <= 1'b0;
		end else begin
			// slow: two cycles an instruction
			core_instr_done <= slow ? !core_instr_done : 1'b1;
			interrupt_return <= ret_cmd;
			// never take beside a return, so flags see one event a cycle
			core_take <= irq_pending && ran_q && !core_take && !ret_cmd &&
				!interrupt_return;
			ran_q <= (core_take || interrupt_return) ? 1'b0 :
				(ran_q || core_instr_done);
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import intc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, global_enable = 1'b0, ret_cmd = 1'b0;
	logic slow = 1'b0, change_protection_wr = 1'b0, rd_q = 1'b0, plc = 1'b0;
	logic core_take, core_instr_done, interrupt_return, irq_pending;
	logic [7:0] change_protection_data = 8'h00, reg_rdata, last;
	logic [31:0] req = '0, pend;
	reg_req_s reg_req = '0;
	vec_out_s vec_out;
	logic [7:0] exp_v[$], exp_r[$];
	int bad_count = 0, checked = 0, cyc = 0;
	always #5 clk = ~clk;
	priority_interrupt_controller i_dut (.clk, .rst, .reg_req, .reg_rdata,
		.global_enable, .core_take, .core_instr_done, .interrupt_return,
		.change_protection_wr, .change_protection_data, .vec_out,
		.irq_pending, .req, .nm_lines(32'h0000_0006));
	core_model i_core (.clk, .rst, .irq_pending, .ret_cmd, .slow, .core_take,
		.core_instr_done, .interrupt_return);
	function automatic logic [7:0] pick(logic [31:0] p, logic r, logic [7:0] l);
		logic [7:0] lo, hi;
		lo = 8'hff;
		hi = 8'hff;
		for (int i = 31; i >= 0; i--) if (p[i]) begin
			lo = 8'(i);
			if (8'(i) > l) hi = 8'(i);
		end
		return (r && hi != 8'hff) ? hi : lo;
	endfunction
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic give_verdict;
		if (exp_v.size() != 0) bad_count++;
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(logic w, logic [1:0] a, logic [7:0] d);
		@(posedge clk);
		reg_req <= '{a, d, w, !w};
		if (!w) exp_r.push_back(d);
		@(posedge clk);
		reg_req <= '0;
	endtask
	task automatic key(logic [7:0] k);
		@(posedge clk);
		change_protection_wr <= 1'b1;
		change_protection_data <= k;
		@(posedge clk);
		change_protection_wr <= 1'b0;
	endtask
	task automatic srv(logic [7:0] v, int idx, bit clr);
		@(posedge clk);
		req[idx] <= 1'b1;
		exp_v.push_back(v);
		for (int i = 0; i < 40 && exp_v.size() != 0; i++) @(negedge clk);
		@(posedge clk);
		if (clr) req[idx] <= 1'b0;
	endtask
	task automatic ret;
		@(posedge clk);
		ret_cmd <= 1'b1;
		@(posedge clk);
		ret_cmd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// ========
	// scoreboard: results sampled mid-cycle, once settled
	always @(negedge clk) begin
		if (rd_q) chk("rdata", reg_rdata, exp_r.pop_front());
		if (vec_out.ack === 1'b1) begin
			chk("vector", vec_out.vector,
				exp_v.size() ? exp_v.pop_front() : 8'hee);
			chk("place", 8'(vec_out.placement), 8'(plc));
		end
		rd_q = reg_req.rd;
		if (++cyc > 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(20969));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++) bus(0, 2'(a), 8'h00);
		bus(1, ofs_executing_flags, 8'hff);
		bus(0, ofs_executing_flags, 8'h00);
		bus(1, ofs_vector_control, 8'h61);
		bus(0, ofs_vector_control, 8'h01);
		key(io_register_key ^ 8'(1 + $urandom % 255));
		bus(1, ofs_vector_control, 8'h60);
		bus(0, ofs_vector_control, 8'h00);
		key(io_register_key);
		repeat (6) @(posedge clk);
		bus(1, ofs_vector_control, 8'h40);
		bus(0, ofs_vector_control, 8'h00);
		key(io_register_key);
		bus(1, ofs_vector_control, 8'h40);
		bus(1, ofs_vector_control, 8'h20);
		bus(0, ofs_vector_control, 8'h40);
		plc = 1'b1;
		global_enable <= 1'b1;
		pend = ($urandom & 32'hffff_fff8) | 32'h200;
		req <= pend;
		while (pend != 0) begin
			last = pick(pend, 1'b0, 8'h00);
			pend[last] = 1'b0;
			srv(last, last, 1);
			ret();
		end
		bus(1, ofs_last_ack, 8'h00);
		bus(1, ofs_vector_control, 8'h41);
		slow <= 1'b1;
		last = 8'h00;
		repeat (4) begin
			req <= 32'h0000_1090;
			last = pick(32'h0000_1090, 1'b1, last);
			srv(last, last, 0);
			req <= '0;
			bus(0, ofs_last_ack, last);
			ret();
		end
		bus(1, ofs_vector_control, 8'h40);
		bus(1, ofs_promoted, 8'h0c);
		srv(8'h04, 4, 1);
		srv(8'h0c, 12, 1);
		bus(0, ofs_executing_flags, 8'h03);
		ret();
		bus(0, ofs_executing_flags, 8'h01);
		ret();
		global_enable <= 1'b0;
		req <= 32'h0000_0106;
		srv(8'h01, 1, 1);
		bus(0, ofs_executing_flags, 8'h80);
		repeat (6) @(posedge clk);
		ret();
		srv(8'h02, 2, 1);
		ret();
		repeat (6) @(posedge clk);
		global_enable <= 1'b1;
		srv(8'h08, 8, 1);
		ret();
		key(io_register_key);
		bus(1, ofs_vector_control, 8'h20);
		plc = 1'b0;
		srv(compact_no_vec, 9, 1);
		srv(compact_hi_vec, 12, 1);
		srv(compact_nm_vec, 1, 1);
		repeat (3) ret();
		give_verdict();
	end
endmodule
`default_nettype wire
